/* File: verilog/alm_pkg.sv */
// package: register map, field layout and carriers of the ambient light block
package alm_pkg;
  localparam logic [7:0] ALM_PARAM_ADDR    = 8'h84;
  localparam logic [7:0] ALM_RES_HI_ADDR   = 8'h85;
  localparam logic [7:0] ALM_RES_LO_ADDR   = 8'h86;
  localparam int         ALM_CONT_BIT      = 7;
  localparam int         ALM_OFS_BIT       = 3;
  localparam int         ALM_AVG_MSB       = 2;
  localparam logic       ALM_CONT_RST      = 1'h0;
  localparam logic       ALM_OFS_RST       = 1'h1;
  localparam logic [2:0] ALM_AVG_RST       = 3'h5;
  localparam int         ALM_RES_W         = 16;
  localparam int         ALM_AVG_W         = 3;

  // register port request from the two-wire bus engine
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } alm_req_s;

  // answer of one converter run
  typedef struct packed {
    logic                 done;
    logic [ALM_RES_W-1:0] data;
  } alm_conv_s;

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_OFFSET = 2'b01,
    S_SAMPLE = 2'b10,
    S_STORE  = 2'b11
  } alm_state_e;
endpackage

/* File: verilog/alm_accum.sv */
// accumulator that sums conversions and yields the shifted mean
`timescale 1ns/1ns
module alm_accum #(
  parameter int DW = 16,
  parameter int SW = 3
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  // control
  input  wire logic          clr_i,
  input  wire logic          add_i,
  input  wire logic [DW-1:0] data_i,
  input  wire logic [SW-1:0] shift_i,
  // mean of what was summed
  output logic      [DW-1:0] mean_o
);
  localparam int AW = DW + (1 << SW) - 1;

  logic [AW-1:0] acc_r;
  logic [AW-1:0] acc_nxt;
  logic [AW-1:0] shifted;

  // clear wins so a new run never inherits old sums
  always_comb
  begin
    acc_nxt = acc_r;
    if (clr_i)
      acc_nxt = '0;
    else if (add_i)
      acc_nxt = acc_r + AW'(data_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      acc_r <= '0;
    else
      acc_r <= acc_nxt;
  end

  // mean of 2^shift samples cannot exceed DW bits
  assign shifted = acc_r >> shift_i;
  assign mean_o  = shifted[DW-1:0];
endmodule

/* File: verilog/alm_ctrl.sv */
// ambient light measurement control with parameter and result registers
`timescale 1ns/1ns
// Function
// - parameter register sits at byte address 0x84
// - bit 7 enables continuous conversion, reset value 0
// - bit 3 enables automatic offset compensation, reset value 1
// - with compensation, measure offset first and subtract it from result
// - bits 2..0 select 2^n conversions per cycle, reset gives 32
// - stored result is the mean of all conversions of one cycle
// - 16-bit result: upper byte at 0x85, lower byte at 0x86
// - result registers are read-only, writes have no effect
// - data-ready set on new result, cleared by reading either result byte
// - start bit launches one averaged measurement, result stored at end (block uses the als_start_i input, no register bit)
module alm_ctrl #(
  parameter int RES_W = alm_pkg::ALM_RES_W,
  parameter int AVG_W = alm_pkg::ALM_AVG_W
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // register port from the serial bus engine
  input  wire alm_pkg::alm_req_s req_i,
  output logic [7:0]             rdata_o,
  // on-demand start and status
  input  wire logic              als_start_i,
  output logic                   als_data_ready_o,
  output logic                   als_busy_o,
  // converter handshake
  output logic                   conv_start_o,
  output logic                   conv_offset_o,
  input  wire alm_pkg::alm_conv_s conv_i
);
  import alm_pkg::*;

  alm_state_e         state_r;
  alm_state_e         state_nxt;
  logic               cont_r;
  logic               cont_nxt;
  logic               ofs_en_r;
  logic               ofs_en_nxt;
  logic [AVG_W-1:0]   avg_r;
  logic [AVG_W-1:0]   avg_nxt;
  logic [AVG_W-1:0]   avg_lat_r;
  logic [AVG_W-1:0]   avg_lat_nxt;
  logic               ofs_lat_r;
  logic               ofs_lat_nxt;
  logic [RES_W-1:0]   offset_r;
  logic [RES_W-1:0]   offset_nxt;
  logic [RES_W-1:0]   result_r;
  logic [RES_W-1:0]   result_nxt;
  logic [8:0]         cnt_r;
  logic [8:0]         cnt_nxt;
  logic               pend_r;
  logic               pend_nxt;
  logic               ready_r;
  logic               ready_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic               start_r;
  logic               start_nxt;
  logic               acc_clr;
  logic               acc_add;
  logic [RES_W-1:0]   mean;
  logic               res_read;
  logic [8:0]         target;
  logic               busy_r;
  logic               busy_nxt;
  logic               ofs_run_r;
  logic               ofs_run_nxt;

  // sums the samples of one cycle
  alm_accum #(
    .DW (RES_W),
    .SW (AVG_W)
  ) u_accum (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .clr_i     (acc_clr),
    .add_i     (acc_add),
    .data_i    (conv_i.data),
    .shift_i   (avg_lat_r),
    .mean_o    (mean)
  );

  assign res_read = req_i.rd && (req_i.addr == ALM_RES_HI_ADDR ||
                                 req_i.addr == ALM_RES_LO_ADDR);
  assign target   = 9'h001 << avg_lat_r;

  // parameter register writes; unused bits are simply not stored
  always_comb
  begin
    cont_nxt   = cont_r;
    ofs_en_nxt = ofs_en_r;
    avg_nxt    = avg_r;
    if (req_i.wr && req_i.addr == ALM_PARAM_ADDR)
    begin
      cont_nxt   = req_i.wdata[ALM_CONT_BIT];
      ofs_en_nxt = req_i.wdata[ALM_OFS_BIT];
      avg_nxt    = req_i.wdata[ALM_AVG_MSB:0];
    end
  end

  // read mux, registered; results ignore writes entirely
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (req_i.rd)
    begin
      case (req_i.addr)
        ALM_PARAM_ADDR:  rdata_nxt = {cont_r, 3'h0, ofs_en_r, avg_r};
        ALM_RES_HI_ADDR: rdata_nxt = result_r[15:8];
        ALM_RES_LO_ADDR: rdata_nxt = result_r[7:0];
        default:         rdata_nxt = 8'h00;
      endcase
    end
  end

  // measurement sequencer: optional offset run, then 2^n samples
  always_comb
  begin
    state_nxt   = state_r;
    avg_lat_nxt = avg_lat_r;
    ofs_lat_nxt = ofs_lat_r;
    offset_nxt  = offset_r;
    result_nxt  = result_r;
    cnt_nxt     = cnt_r;
    pend_nxt    = pend_r;
    start_nxt   = 1'b0;
    acc_clr     = 1'b0;
    acc_add     = 1'b0;
    // set wins over a read in the same cycle
    ready_nxt   = res_read ? 1'b0 : ready_r;
    case (state_r)
      S_IDLE:
      begin
        if (als_start_i || cont_r)
        begin
          avg_lat_nxt = avg_r;
          ofs_lat_nxt = ofs_en_r;
          offset_nxt  = '0;
          cnt_nxt     = 9'h000;
          pend_nxt    = 1'b0;
          acc_clr     = 1'b1;
          state_nxt   = ofs_en_r ? S_OFFSET : S_SAMPLE;
        end
      end
      S_OFFSET, S_SAMPLE:
      begin
        if (!pend_r)
        begin
          start_nxt = 1'b1;
          pend_nxt  = 1'b1;
        end
        else if (conv_i.done)
        begin
          pend_nxt = 1'b0;
          if (state_r == S_OFFSET)
          begin
            offset_nxt = conv_i.data;
            state_nxt  = S_SAMPLE;
          end
          else
          begin
            acc_add = 1'b1;
            cnt_nxt = cnt_r + 9'h001;
            if (cnt_r + 9'h001 == target)
              state_nxt = S_STORE;
          end
        end
      end
      S_STORE:
      begin
        // setting latched at cycle start, so a mid-run write cannot skew it;
        // negative corrected readings clamp to zero
        if (ofs_lat_r && mean > offset_r)
          result_nxt = mean - offset_r;
        else if (ofs_lat_r)
          result_nxt = '0;
        else
          result_nxt = mean;
        ready_nxt  = 1'b1;
        if (cont_r)
        begin
          // restart straight away without a new start command
          avg_lat_nxt = avg_r;
          ofs_lat_nxt = ofs_en_r;
          offset_nxt  = '0;
          cnt_nxt     = 9'h000;
          pend_nxt    = 1'b0;
          acc_clr     = 1'b1;
          state_nxt   = ofs_en_r ? S_OFFSET : S_SAMPLE;
        end
        else
          state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
    // status outputs registered from the next state, same timing as state_r
    busy_nxt    = (state_nxt != S_IDLE);
    ofs_run_nxt = (state_nxt == S_OFFSET);
  end

  // all state registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r   <= S_IDLE;
      cont_r    <= ALM_CONT_RST;
      ofs_en_r  <= ALM_OFS_RST;
      avg_r     <= ALM_AVG_RST;
      avg_lat_r <= ALM_AVG_RST;
      ofs_lat_r <= ALM_OFS_RST;
      offset_r  <= '0;
      result_r  <= '0;
      cnt_r     <= 9'h000;
      pend_r    <= 1'b0;
      ready_r   <= 1'b0;
      rdata_r   <= 8'h00;
      start_r   <= 1'b0;
      busy_r    <= 1'b0;
      ofs_run_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      cont_r    <= cont_nxt;
      ofs_en_r  <= ofs_en_nxt;
      avg_r     <= avg_nxt;
      avg_lat_r <= avg_lat_nxt;
      ofs_lat_r <= ofs_lat_nxt;
      offset_r  <= offset_nxt;
      result_r  <= result_nxt;
      cnt_r     <= cnt_nxt;
      pend_r    <= pend_nxt;
      ready_r   <= ready_nxt;
      rdata_r   <= rdata_nxt;
      start_r   <= start_nxt;
      busy_r    <= busy_nxt;
      ofs_run_r <= ofs_run_nxt;
    end
  end

  // outputs straight from flops
  assign rdata_o          = rdata_r;
  assign als_data_ready_o = ready_r;
  assign conv_start_o     = start_r;
  assign conv_offset_o    = ofs_run_r;
  assign als_busy_o       = busy_r;

  param_write_a: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (req_i.wr && req_i.addr == ALM_PARAM_ADDR)
      |=> cont_r == $past(req_i.wdata[ALM_CONT_BIT]))
    else $error("parameter write not taken");
  reset_vals_a: assert property (@(posedge clk_i)
    sys_rst_i |=> (cont_r == ALM_CONT_RST && ofs_en_r == ALM_OFS_RST &&
                   avg_r == ALM_AVG_RST))
    else $error("parameter reset value wrong");
  unused_zero_a: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (req_i.rd && req_i.addr == ALM_PARAM_ADDR) |=> rdata_o[6:4] == 3'h0)
    else $error("unused bits not zero");
  offset_first_a: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (state_r == S_IDLE && state_nxt != S_IDLE && ofs_en_r)
      |=> state_r == S_OFFSET)
    else $error("offset not measured first");
  sample_count_a: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (state_r == S_STORE) |-> cnt_r == (9'h001 << avg_lat_r))
    else $error("wrong number of conversions");
  result_ro_a: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (req_i.wr && state_r != S_STORE) |=> $stable(result_r))
    else $error("result changed by write");
  ready_set_a: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (state_r == S_STORE) |=> als_data_ready_o)
    else $error("data ready not set");
  ready_clr_a: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (res_read && state_r != S_STORE) |=> !als_data_ready_o)
    else $error("data ready not cleared");
  start_go_a: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (state_r == S_IDLE && als_start_i) |=> als_busy_o ##1 conv_start_o)
    else $error("start not honoured");
  cont_run_a: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (state_r == S_STORE && cont_r) |=> state_r != S_IDLE)
    else $error("continuous mode stopped");
endmodule

/* File: verif/alm_conv_model.sv */
// converter stand-in that answers start pulses after a set delay
`timescale 1ns/1ns
module alm_conv_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // from the block
  input  wire logic        start_i,
  input  wire logic        offset_i,
  input  wire logic        busy_i,
  // from the bench: delay, sample and offset values
  input  wire logic [3:0]  dly_i,
  input  wire logic [15:0] smp_i,
  input  wire logic [15:0] ofs_i,
  // answer
  output alm_pkg::alm_conv_s conv_o
);
  import alm_pkg::*;
  logic [3:0] cnt_r;
  logic       run_r;
  logic       odd_r;
  // samples alternate v and v+2 so the mean is v+1 for even counts;
  // data is scrambled outside done so a stale value is never trusted
  always_ff @(posedge clk_i)
  begin
    conv_o.done <= 1'b0;
    conv_o.data <= ~conv_o.data;
    if (!busy_i)
      odd_r <= 1'b0;
    if (sys_rst_i)
    begin
      run_r <= 1'b0;
      conv_o.data <= 16'h0000;
    end
    else if (start_i)
    begin
      run_r <= 1'b1;
      cnt_r <= dly_i;
    end
    else if (run_r && cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
    else if (run_r)
    begin
      run_r <= 1'b0;
      conv_o.done <= 1'b1;
      conv_o.data <= offset_i ? ofs_i : smp_i + (odd_r ? 16'h2 : 16'h0);
      if (!offset_i)
        odd_r <= !odd_r;
    end
  end
endmodule

/* File: verif/tb_top.sv */
// bench: register and measurement sequences against the light block
`timescale 1ns/1ns
module tb_top;
  import alm_pkg::*;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        start = 1'b0;
  alm_req_s    req = '0;
  logic [7:0]  rdata;
  logic        rdy, busy, cst, coff, seen;
  alm_conv_s   conv;
  logic [3:0]  dly = 4'h0;
  logic [15:0] smp = 16'h01A4;
  logic [15:0] ofs = 16'h0021;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;

  alm_ctrl alm_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .rdata_o(rdata), .als_start_i(start), .als_data_ready_o(rdy),
    .als_busy_o(busy), .conv_start_o(cst), .conv_offset_o(coff),
    .conv_i(conv));
  alm_conv_model alm_conv_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .start_i(cst), .offset_i(coff), .busy_i(busy), .dly_i(dly),
    .smp_i(smp), .ofs_i(ofs), .conv_o(conv));

  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  // hang guard and offset-run monitor
  always @(posedge clk_i)
  begin
    cyc++;
    if (coff === 1'b1)
      seen = 1'b1;
    if (cyc == 40000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one byte access, strobe held for exactly one edge
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] wd);
    @(posedge clk_i);
    req <= '{addr: a, wr: w, rd: !w, wdata: wd};
    @(posedge clk_i);
    req <= '0;
    #1;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK("rdata", e, rdata)
  endtask
  // start pulse, then bounded wait for data ready
  task automatic measure(input logic pulse);
    int n = 0;
    seen = 1'b0;
    @(posedge clk_i);
    start <= pulse;
    @(posedge clk_i);
    start <= 1'b0;
    while (rdy !== 1'b1 && n < 3000)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    `CHK("ready", 1'b1, rdy)
  endtask

  // test sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1 `CHK("ready", 1'b0, rdy)
    `CHK("busy", 1'b0, busy)
    chk_rd(ALM_PARAM_ADDR, 8'h0D);
    $display("test reset done");
    acc(1'b1, ALM_PARAM_ADDR, 8'h7A);
    chk_rd(ALM_PARAM_ADDR, 8'h0A);
    chk_rd(8'h90, 8'h00);
    $display("test param done");
    acc(1'b1, ALM_PARAM_ADDR, 8'h00);
    measure(1'b1);
    `CHK("offset run", 1'b0, seen)
    chk_rd(ALM_RES_HI_ADDR, 8'h01);
    `CHK("ready", 1'b0, rdy)
    chk_rd(ALM_RES_LO_ADDR, 8'hA4);
    $display("test single done");
    // slow converter, offset on, four samples: mean 1A5 minus 21
    acc(1'b1, ALM_PARAM_ADDR, 8'h0A);
    dly = 4'h5;
    measure(1'b1);
    `CHK("offset run", 1'b1, seen)
    chk_rd(ALM_RES_LO_ADDR, 8'h84);
    `CHK("ready", 1'b0, rdy)
    acc(1'b1, ALM_RES_LO_ADDR, 8'hFF);
    chk_rd(ALM_RES_LO_ADDR, 8'h84);
    chk_rd(ALM_RES_HI_ADDR, 8'h01);
    $display("test offset done");
    // 128 conversions, prompt answers
    acc(1'b1, ALM_PARAM_ADDR, 8'h07);
    dly = 4'h0;
    measure(1'b1);
    chk_rd(ALM_RES_LO_ADDR, 8'hA5);
    $display("test avg128 done");
    // continuous mode restarts without a start pulse
    acc(1'b1, ALM_PARAM_ADDR, 8'h80);
    measure(1'b0);
    repeat (2) @(posedge clk_i);
    #1 `CHK("busy", 1'b1, busy)
    chk_rd(ALM_RES_LO_ADDR, 8'hA4);
    acc(1'b1, ALM_PARAM_ADDR, 8'h00);
    repeat (20) @(posedge clk_i);
    #1 `CHK("busy", 1'b0, busy)
    $display("test continuous done");
    conclude();
  end
endmodule
